// [hdl/ripple_params.svh]
// offsets, field positions, reset values and timing counts of the ripple counter
`ifndef RIPPLE_PARAMS_SVH
`define RIPPLE_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------------
`define REG_CONTROL      8'h00
`define REG_MOTOR        8'h01
`define REG_FILTER       8'h02
`define REG_THRESHOLD    8'h03
`define REG_COUNT        8'h04
`define REG_STATUS       8'h05
`define REG_PERIOD       8'h06

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTL_ENABLE       0
`define CTL_CLEAR        1
`define CTL_VSENSE       2
`define CTL_EC_DIS       3
`define CTL_EC_OUT_DIS   4
`define CTL_REPORT_HI    6
`define CTL_REPORT_LO    5
`define MOT_COND_HI      7
`define MOT_COND_LO      0
`define MOT_CSCALE_HI    9
`define MOT_CSCALE_LO    8
`define MOT_ESCALE_HI    11
`define MOT_ESCALE_LO    10
`define MOT_GAIN_HI      13
`define MOT_GAIN_LO      12
`define FLT_EMF_HI       7
`define FLT_EMF_LO       0
`define FLT_DAMP_HI      11
`define FLT_DAMP_LO      8
`define FLT_MECH_HI      15
`define FLT_MECH_LO      12
`define THR_VALUE_HI     7
`define THR_VALUE_LO     0
`define THR_SCALE_HI     9
`define THR_SCALE_LO     8
`define THR_OUTFLT_HI    13
`define THR_OUTFLT_LO    10
`define STS_DONE         0
`define STS_MUTED        1
`define STS_PULSE_PIN    2
`define STS_FAULT_PIN    3

// ----------------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------------
`define RST_DAMPING      4'h8
`define RST_MECH         4'h4
`define RST_OUTPUT_FILTER_CUTOFF      4'h3
`define EMF_BASE         24
`define INSERT_LIMIT     4'hC
`define COUNT_MAX        16'hFFFF
`define CSHIFT_MIN       4'h5
`define CSHIFT_MAX       4'hB

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS    100
`define PULSE_TIME_NS    50000
`define PULSE_CYCLES     ((`PULSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [hdl/ripple_pkg.sv]
// types shared by the ripple counter
package ripple_pkg;

	typedef enum logic [1:0] {EC_IDLE, EC_TRACK, EC_MUTED} ec_state_t;

	typedef logic [9:0] timer_t;

	typedef struct packed {
		logic       ripple_count_enable;
		logic       voltage_sense_filter_select;
		logic       error_corrector_disable;
		logic       corrector_output_disable;
		logic [1:0] ripple_fault_report_select;
		logic [7:0] scaled_motor_conductance;
		logic [1:0] conductance_scale_select;
		logic [1:0] backemf_constant_scale;
		logic [1:0] bandpass_gain_select;
		logic [7:0] backemf_constant_value;
		logic [3:0] bandpass_damping;
		logic [3:0] mechanical_lowpass_setting;
		logic [7:0] ripple_threshold_value;
		logic [1:0] ripple_threshold_scale;
		logic [3:0] output_filter_cutoff;
	} cfg_t;

	typedef struct packed {
		cfg_t               cfg;
		logic signed [23:0] lp_fast;
		logic signed [23:0] lp_slow;
		logic               armed;
		logic signed [23:0] v_filt;
		logic [31:0]        phase;
		ec_state_t          ec;
		logic               bp_seen;
		logic               accepted;
		logic [3:0]         insert_run;
		logic [15:0]        gap;
		logic signed [23:0] period;
		logic [15:0]        ripple_count_value;
		logic               count_reached_flag;
		timer_t             pulse_timer;
		timer_t             fault_timer;
		logic               rc_oe;
		logic               fault_oe;
		logic [15:0]        rdata;
	} state_t;

endpackage

// [hdl/motor_ripple_counter.sv]
// sensorless ripple counter for a brushed dc motor driver
//
// Summary of operation
// - counting runs only while enable bit set
// - conductance scale codes give 2/64/1024/8192
// - emf scale codes give 24 times 2^8/9/12/13
// - bandpass input gain codes give 2/4/8/16
// - damping sets bandpass quality factor
// - bandpass centred on estimated ripple frequency
// - threshold count is value times scale
// - sixteen-bit ripple count register
// - done flag latches above threshold until clear
// - clear command zeroes count and done flag; a ripple in the same cycle leaves the count at 1
// - report select decides fault pin behaviour
// - threshold scale codes give 2/8/16/64
// - mechanical setting low-passes the counter response
// - sense select: analog at 0, digital at 1
// - digital sense is duty times supply
// - analog sense cut-off from output filter setting
// - corrector enabled at 0, disabled at 1
// - corrector keeps pulsing without real ripples
// - mute after twelve inserted pulses, none real
// - one 50 us positive pulse per ripple
// - report codes: hold or wrap, fault low
`timescale 1ns/100ps
`include "ripple_params.svh"

module motor_ripple_counter
	import ripple_pkg::*;
#(
	parameter logic signed [23:0] DETECT_HYSTERESIS = 24'h00_0040
) (
	input  wire logic        MCLK_I,
	input  wire logic        RST_I,
	input  wire logic [7:0]  ADDRESS_I,
	input  wire logic [15:0] WRITE_DATA_I,
	input  wire logic        WRITE_STROBE_I,
	input  wire logic        READ_STROBE_I,
	output logic      [15:0] READ_DATA_O,
	input  wire logic [15:0] CURRENT_SAMPLE_I,
	input  wire logic        SAMPLE_STROBE_I,
	input  wire logic [7:0]  PWM_DUTY_I,
	input  wire logic [11:0] MOTOR_SUPPLY_VOLTAGE_I,
	input  wire logic [11:0] OUTPUT_VOLTAGE_I,
	input  wire logic        RIPPLE_PULSE_OUTPUT_I,
	output logic             RIPPLE_PULSE_OUTPUT_O,
	output logic             RIPPLE_PULSE_OUTPUT_OE_O,
	input  wire logic        FAULT_OUTPUT_LOW_N_I,
	output logic             FAULT_OUTPUT_LOW_N_O,
	output logic             FAULT_OUTPUT_LOW_N_OE_O
);

	// ------------------------------------------------------------------------
	// scale decoding
	// ------------------------------------------------------------------------
	// every scale is a power of two, so it is applied as a shift
	function automatic logic [3:0] conductance_shift(input logic [1:0] sel);
		case (sel)
			2'h0:    conductance_shift = 4'h1;
			2'h1:    conductance_shift = 4'h6;
			2'h2:    conductance_shift = 4'hA;
			default: conductance_shift = 4'hD;
		endcase
	endfunction
	function automatic logic [3:0] emf_shift(input logic [1:0] sel);
		case (sel)
			2'h0:    emf_shift = 4'h8;
			2'h1:    emf_shift = 4'h9;
			2'h2:    emf_shift = 4'hC;
			default: emf_shift = 4'hD;
		endcase
	endfunction
	function automatic logic [3:0] threshold_shift(input logic [1:0] sel);
		case (sel)
			2'h0:    threshold_shift = 4'h1;
			2'h1:    threshold_shift = 4'h3;
			2'h2:    threshold_shift = 4'h4;
			default: threshold_shift = 4'h6;
		endcase
	endfunction
	// first-order low-pass step shared by the filters
	function automatic logic signed [23:0] lp_step(input logic signed [23:0] acc,
		input logic signed [23:0] target, input logic [3:0] sh);
		lp_step = acc + ((target - acc) >>> sh);
	endfunction
	// centre shift from the ripple period: one shift per octave of period
	function automatic logic [3:0] centre_shift(input logic signed [23:0] per);
		logic [3:0] pos;
		pos = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (per[i]) begin
				pos = 4'(i);
			end
		end
		if (pos < `CSHIFT_MIN) begin
			pos = `CSHIFT_MIN;
		end
		if (pos > `CSHIFT_MAX) begin
			pos = `CSHIFT_MAX;
		end
		centre_shift = pos;
	endfunction

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	state_t             s;
	state_t             n;
	logic               clear;
	logic               running;
	logic               bp_pulse;
	logic               model_pulse;
	logic               emit;
	logic               wrap;
	logic [3:0]         cshift;
	logic [3:0]         band;
	logic signed [23:0] x;
	logic signed [23:0] bp;
	logic [19:0]        duty_prod;
	logic [11:0]        v_est;
	logic [19:0]        drive;
	logic signed [20:0] emf_i;
	logic [47:0]        phase_lhs;
	logic [47:0]        phase_rhs;
	logic [16:0]        thr_count;
	always_comb begin
		n           = s;
		clear       = 1'b0;
		bp_pulse    = 1'b0;
		model_pulse = 1'b0;
		emit        = 1'b0;
		wrap        = 1'b0;
		running     = s.cfg.ripple_count_enable;

		// --------------------------------------------------------------------
		// register writes
		// --------------------------------------------------------------------
		if (WRITE_STROBE_I) begin
			case (ADDRESS_I)
				`REG_CONTROL: begin
					n.cfg.ripple_count_enable         = WRITE_DATA_I[`CTL_ENABLE];
					n.cfg.voltage_sense_filter_select = WRITE_DATA_I[`CTL_VSENSE];
					n.cfg.error_corrector_disable     = WRITE_DATA_I[`CTL_EC_DIS];
					n.cfg.corrector_output_disable    = WRITE_DATA_I[`CTL_EC_OUT_DIS];
					n.cfg.ripple_fault_report_select  = WRITE_DATA_I[`CTL_REPORT_HI:`CTL_REPORT_LO];
					clear                             = WRITE_DATA_I[`CTL_CLEAR];
				end
				`REG_MOTOR: begin
					n.cfg.scaled_motor_conductance = WRITE_DATA_I[`MOT_COND_HI:`MOT_COND_LO];
					n.cfg.conductance_scale_select = WRITE_DATA_I[`MOT_CSCALE_HI:`MOT_CSCALE_LO];
					n.cfg.backemf_constant_scale   = WRITE_DATA_I[`MOT_ESCALE_HI:`MOT_ESCALE_LO];
					n.cfg.bandpass_gain_select     = WRITE_DATA_I[`MOT_GAIN_HI:`MOT_GAIN_LO];
				end
				`REG_FILTER: begin
					n.cfg.backemf_constant_value     = WRITE_DATA_I[`FLT_EMF_HI:`FLT_EMF_LO];
					n.cfg.bandpass_damping           = WRITE_DATA_I[`FLT_DAMP_HI:`FLT_DAMP_LO];
					n.cfg.mechanical_lowpass_setting = WRITE_DATA_I[`FLT_MECH_HI:`FLT_MECH_LO];
				end
				`REG_THRESHOLD: begin
					n.cfg.ripple_threshold_value = WRITE_DATA_I[`THR_VALUE_HI:`THR_VALUE_LO];
					n.cfg.ripple_threshold_scale = WRITE_DATA_I[`THR_SCALE_HI:`THR_SCALE_LO];
					n.cfg.output_filter_cutoff   = WRITE_DATA_I[`THR_OUTFLT_HI:`THR_OUTFLT_LO];
				end
				default: begin
				end
			endcase
		end

		// --------------------------------------------------------------------
		// band-pass ripple detector
		// --------------------------------------------------------------------
		// shift amount widened so code 3 gives x16 instead of wrapping to x1
		x      = 24'(CURRENT_SAMPLE_I) <<< (3'(s.cfg.bandpass_gain_select) + 3'h1);
		cshift = centre_shift(s.period);
		// a high damping value brings the poles together, narrowing the band
		band   = 4'(((4'hF - s.cfg.bandpass_damping) >> 2) + 4'h1);
		bp     = s.lp_fast - s.lp_slow;
		if (running && SAMPLE_STROBE_I) begin
			n.lp_fast = lp_step(s.lp_fast, x, cshift - band);
			n.lp_slow = lp_step(s.lp_slow, x, cshift + band);
			if (bp < -DETECT_HYSTERESIS) begin
				n.armed = 1'b1;
			end else if (s.armed && bp > DETECT_HYSTERESIS) begin
				n.armed  = 1'b0;
				bp_pulse = 1'b1;
			end
		end

		// --------------------------------------------------------------------
		// motor voltage estimate and back-emf ripple model
		// --------------------------------------------------------------------
		duty_prod = 20'(PWM_DUTY_I * MOTOR_SUPPLY_VOLTAGE_I);
		if (SAMPLE_STROBE_I) begin
			n.v_filt = lp_step(s.v_filt, 24'(OUTPUT_VOLTAGE_I), s.cfg.output_filter_cutoff);
		end
		if (s.cfg.voltage_sense_filter_select) begin
			v_est = duty_prod[19:8];
		end else begin
			v_est = s.v_filt[11:0];
		end
		// current the supply would push through the winding resistance alone
		drive     = 20'(v_est * s.cfg.scaled_motor_conductance) >> conductance_shift(s.cfg.conductance_scale_select);
		emf_i     = 21'(drive) - 21'(CURRENT_SAMPLE_I);
		// emf integral meets the per-ripple constant once per ripple; cross-multiplied, no divider
		phase_lhs = 48'(s.phase) << conductance_shift(s.cfg.conductance_scale_select);
		phase_rhs = (48'(s.cfg.backemf_constant_value) * 48'(`EMF_BASE) * 48'(s.cfg.scaled_motor_conductance))
			<< emf_shift(s.cfg.backemf_constant_scale);
		if (running && SAMPLE_STROBE_I) begin
			if (phase_rhs != 48'h0000_0000_0000 && phase_lhs >= phase_rhs) begin
				model_pulse = 1'b1;
				n.phase     = 32'h0000_0000;
			end else if (emf_i > 21'sh00_0000) begin
				n.phase = s.phase + 32'(emf_i[19:0]);
			end
			if (s.gap != 16'hFFFF) begin
				n.gap = s.gap + 16'h0001;
			end
		end

		// --------------------------------------------------------------------
		// error corrector
		// --------------------------------------------------------------------
		if (!running || s.cfg.error_corrector_disable) begin
			n.ec       = EC_IDLE;
			n.bp_seen  = 1'b0;
			n.accepted = 1'b0;
			n.insert_run = 4'h0;
		end else if (s.ec == EC_IDLE) begin
			n.ec = EC_TRACK;
		end else if (bp_pulse) begin
			// a second real ripple in one expected interval is an extra one
			if (!s.accepted) begin
				emit         = 1'b1;
				n.ec         = EC_TRACK;
				n.accepted   = 1'b1;
				n.bp_seen    = 1'b1;
				n.insert_run = 4'h0;
				n.gap        = 16'h0000;
				n.period     = lp_step(s.period, 24'(s.gap), s.cfg.mechanical_lowpass_setting);
			end
		end else if (model_pulse) begin
			n.bp_seen  = 1'b0;
			n.accepted = 1'b0;
			if (!s.bp_seen) begin
				emit = (s.ec == EC_TRACK);
				if (s.insert_run != `INSERT_LIMIT) begin
					n.insert_run = s.insert_run + 4'h1;
				end
				if (s.cfg.corrector_output_disable && s.insert_run + 4'h1 >= `INSERT_LIMIT) begin
					n.ec = EC_MUTED;
				end
			end
		end

		// --------------------------------------------------------------------
		// ripple counter and done flag
		// --------------------------------------------------------------------
		if (emit) begin
			if (s.ripple_count_value == `COUNT_MAX) begin
				if (s.cfg.ripple_fault_report_select[0]) begin
					n.ripple_count_value = 16'h0000;
					wrap                 = 1'b1;
				end
			end else begin
				n.ripple_count_value = s.ripple_count_value + 16'h0001;
			end
		end
		if (clear) begin
			n.ripple_count_value = {15'h0000, emit};
		end
		thr_count = 17'(s.cfg.ripple_threshold_value) << threshold_shift(s.cfg.ripple_threshold_scale);
		// set is judged on the cleared count, so a clear never re-arms itself
		n.count_reached_flag = (17'(n.ripple_count_value) > thr_count)
			| (s.count_reached_flag & ~clear);

		// --------------------------------------------------------------------
		// pin timing
		// --------------------------------------------------------------------
		if (emit) begin
			n.pulse_timer = timer_t'(`PULSE_CYCLES);
		end else if (s.pulse_timer != timer_t'(0)) begin
			n.pulse_timer = s.pulse_timer - timer_t'(1);
		end
		if (wrap && s.cfg.ripple_fault_report_select == 2'h3) begin
			n.fault_timer = timer_t'(`PULSE_CYCLES);
		end else if (s.fault_timer != timer_t'(0)) begin
			n.fault_timer = s.fault_timer - timer_t'(1);
		end
		// open drain: released while the pulse is high, pulled low otherwise
		n.rc_oe = (n.pulse_timer == timer_t'(0));
		case (s.cfg.ripple_fault_report_select)
			2'h2:    n.fault_oe = n.count_reached_flag;
			2'h3:    n.fault_oe = (n.fault_timer != timer_t'(0));
			default: n.fault_oe = 1'b0;
		endcase

		// --------------------------------------------------------------------
		// register reads
		// --------------------------------------------------------------------
		n.rdata = 16'h0000;
		if (READ_STROBE_I) begin
			case (ADDRESS_I)
				`REG_CONTROL: begin
					n.rdata[`CTL_ENABLE]                    = s.cfg.ripple_count_enable;
					n.rdata[`CTL_VSENSE]                    = s.cfg.voltage_sense_filter_select;
					n.rdata[`CTL_EC_DIS]                    = s.cfg.error_corrector_disable;
					n.rdata[`CTL_EC_OUT_DIS]                = s.cfg.corrector_output_disable;
					n.rdata[`CTL_REPORT_HI:`CTL_REPORT_LO]  = s.cfg.ripple_fault_report_select;
				end
				`REG_MOTOR: begin
					n.rdata[`MOT_COND_HI:`MOT_COND_LO]      = s.cfg.scaled_motor_conductance;
					n.rdata[`MOT_CSCALE_HI:`MOT_CSCALE_LO]  = s.cfg.conductance_scale_select;
					n.rdata[`MOT_ESCALE_HI:`MOT_ESCALE_LO]  = s.cfg.backemf_constant_scale;
					n.rdata[`MOT_GAIN_HI:`MOT_GAIN_LO]      = s.cfg.bandpass_gain_select;
				end
				`REG_FILTER: begin
					n.rdata[`FLT_EMF_HI:`FLT_EMF_LO]        = s.cfg.backemf_constant_value;
					n.rdata[`FLT_DAMP_HI:`FLT_DAMP_LO]      = s.cfg.bandpass_damping;
					n.rdata[`FLT_MECH_HI:`FLT_MECH_LO]      = s.cfg.mechanical_lowpass_setting;
				end
				`REG_THRESHOLD: begin
					n.rdata[`THR_VALUE_HI:`THR_VALUE_LO]    = s.cfg.ripple_threshold_value;
					n.rdata[`THR_SCALE_HI:`THR_SCALE_LO]    = s.cfg.ripple_threshold_scale;
					n.rdata[`THR_OUTFLT_HI:`THR_OUTFLT_LO]  = s.cfg.output_filter_cutoff;
				end
				`REG_COUNT: begin
					n.rdata = s.ripple_count_value;
				end
				`REG_STATUS: begin
					n.rdata[`STS_DONE]      = s.count_reached_flag;
					n.rdata[`STS_MUTED]     = (s.ec == EC_MUTED);
					n.rdata[`STS_PULSE_PIN] = RIPPLE_PULSE_OUTPUT_I;
					n.rdata[`STS_FAULT_PIN] = FAULT_OUTPUT_LOW_N_I;
				end
				`REG_PERIOD: begin
					n.rdata = s.period[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			s                                <= '0;
			s.cfg.bandpass_damping           <= `RST_DAMPING;
			s.cfg.mechanical_lowpass_setting <= `RST_MECH;
			s.cfg.output_filter_cutoff       <= `RST_OUTPUT_FILTER_CUTOFF;
			s.ec                             <= EC_IDLE;
			s.rc_oe                          <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	// both pins are open drain: the driven level is always low
	assign READ_DATA_O             = s.rdata;
	assign RIPPLE_PULSE_OUTPUT_O   = s.fault_oe & 1'b0;
	assign RIPPLE_PULSE_OUTPUT_OE_O = s.rc_oe;
	assign FAULT_OUTPUT_LOW_N_O    = s.rc_oe & 1'b0;
	assign FAULT_OUTPUT_LOW_N_OE_O = s.fault_oe;

endmodule // motor_ripple_counter

// [sim/motor_ripple_counter_props.sv]
// port assertions for the ripple counter
`timescale 1ns/100ps
`include "ripple_params.svh"
module motor_ripple_counter_props (
	input wire logic        MCLK_I,
	input wire logic        RST_I,
	input wire logic [7:0]  ADDRESS_I,
	input wire logic [15:0] WRITE_DATA_I,
	input wire logic        WRITE_STROBE_I,
	input wire logic        READ_STROBE_I,
	input wire logic [15:0] READ_DATA_O,
	input wire logic        RIPPLE_PULSE_OUTPUT_O,
	input wire logic        RIPPLE_PULSE_OUTPUT_OE_O,
	input wire logic        FAULT_OUTPUT_LOW_N_O,
	input wire logic        FAULT_OUTPUT_LOW_N_OE_O
);
	// ------------------------------------------------------------
	// control shadow and pulse length counter
	// ------------------------------------------------------------
	logic [1:0]  rep;
	logic        en;
	logic        ecd;
	logic [10:0] lo_cnt;
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			rep <= 2'h0;
			en <= 1'b0;
			ecd <= 1'b0;
			lo_cnt <= 11'h000;
		end else begin
			if (WRITE_STROBE_I && ADDRESS_I == `REG_CONTROL) begin
				rep <= WRITE_DATA_I[`CTL_REPORT_HI:`CTL_REPORT_LO];
				en <= WRITE_DATA_I[`CTL_ENABLE];
				ecd <= WRITE_DATA_I[`CTL_EC_DIS];
			end
			// saturate: retriggered pulses may run long
			if (RIPPLE_PULSE_OUTPUT_OE_O) begin
				lo_cnt <= 11'h000;
			end else if (lo_cnt != 11'h7FF) begin
				lo_cnt <= lo_cnt + 11'h001;
			end
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	sequence ctl_read;
		READ_STROBE_I && ADDRESS_I == `REG_CONTROL;
	endsequence
	sequence pulse_end;
		$rose(RIPPLE_PULSE_OUTPUT_OE_O);
	endsequence
	read_idle_zero_a: assert property (!$past(READ_STROBE_I) |-> READ_DATA_O == 16'h0000)
		else $error("read data not zero outside a read");
	clear_reads_zero_a: assert property (ctl_read |=> READ_DATA_O[`CTL_CLEAR] == 1'b0)
		else $error("clear bit reads back as one");
	pulse_width_a: assert property (pulse_end |-> lo_cnt >= `PULSE_CYCLES)
		else $error("ripple pulse too short");
	pins_drive_low_a: assert property (!RIPPLE_PULSE_OUTPUT_O && !FAULT_OUTPUT_LOW_N_O)
		else $error("open drain pin driven high");
	pulse_needs_en_a: assert property ($fell(RIPPLE_PULSE_OUTPUT_OE_O) |-> en || $past(en))
		else $error("pulse while counting disabled");
	pulse_needs_ec_a: assert property ($fell(RIPPLE_PULSE_OUTPUT_OE_O) |-> !ecd || !$past(ecd))
		else $error("pulse while corrector disabled");
	fault_quiet_a: assert property (!rep[1] && !$past(rep[1]) |-> !FAULT_OUTPUT_LOW_N_OE_O)
		else $error("fault pin pulled without report");
	fault_hold_a: assert property (FAULT_OUTPUT_LOW_N_OE_O && rep == 2'b10 && !WRITE_STROBE_I
		|=> FAULT_OUTPUT_LOW_N_OE_O)
		else $error("fault pin released without clear");
	fault_cause_a: assert property ($rose(FAULT_OUTPUT_LOW_N_OE_O) |-> rep[1] || $past(rep[1]))
		else $error("fault pin pulled under quiet report");
endmodule // motor_ripple_counter_props

bind motor_ripple_counter motor_ripple_counter_props i_props (
	.MCLK_I(MCLK_I), .RST_I(RST_I), .ADDRESS_I(ADDRESS_I), .WRITE_DATA_I(WRITE_DATA_I),
	.WRITE_STROBE_I(WRITE_STROBE_I), .READ_STROBE_I(READ_STROBE_I), .READ_DATA_O(READ_DATA_O),
	.RIPPLE_PULSE_OUTPUT_O(RIPPLE_PULSE_OUTPUT_O), .RIPPLE_PULSE_OUTPUT_OE_O(RIPPLE_PULSE_OUTPUT_OE_O),
	.FAULT_OUTPUT_LOW_N_O(FAULT_OUTPUT_LOW_N_O), .FAULT_OUTPUT_LOW_N_OE_O(FAULT_OUTPUT_LOW_N_OE_O)
);

// [sim/motor_partner.sv]
// motor current and pin pull-up model facing the ripple counter
`timescale 1ns/100ps
module motor_partner (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        connected_i,
	input  wire logic        pulse_oe_i,
	input  wire logic        fault_oe_i,
	output logic      [15:0] sample_o,
	output logic             strobe_o,
	output logic             pulse_pin_o,
	output logic             fault_pin_o
);
	logic [3:0]  div;
	logic [4:0]  phase;
	logic [3:0]  tri_lvl;
	logic [15:0] cur;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div <= 4'h0;
			phase <= 5'h00;
		end else begin
			div <= div + 4'h1;
			if (div == 4'hF) begin
				phase <= phase + 5'h01;
			end
		end
	end
	// one ripple every 512 cycles, a bit longer than one output pulse
	assign strobe_o = (div == 4'hF);
	assign tri_lvl = phase[4] ? ~phase[3:0] : phase[3:0];
	// a disconnected winding draws nothing, so only inserted ripples remain
	assign cur = connected_i ? (16'h0400 + {8'h00, tri_lvl, 4'h0}) : 16'h0000;
	// outside the strobe the line carries garbage, not the last sample
	assign sample_o = strobe_o ? cur : ~cur;
	assign pulse_pin_o = !pulse_oe_i;
	assign fault_pin_o = !fault_oe_i;
endmodule // motor_partner

// [sim/motor_ripple_counter_tb_top.sv]
// self-checking bench for the ripple counter
`timescale 1ns/100ps
`include "ripple_params.svh"
module motor_ripple_counter_tb_top;
	logic        mclk, rst, wr_stb, rd_stb, connected, strobe, pulse_o, pulse_oe, pulse_pin;
	logic        fault_o, fault_oe, fault_pin;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata, cur, v;
	int          n_fail = 0;
	int          compares = 0;
	motor_ripple_counter i_dut (.MCLK_I(mclk), .RST_I(rst), .ADDRESS_I(addr), .WRITE_DATA_I(wdata),
		.WRITE_STROBE_I(wr_stb), .READ_STROBE_I(rd_stb), .READ_DATA_O(rdata), .CURRENT_SAMPLE_I(cur),
		.SAMPLE_STROBE_I(strobe), .PWM_DUTY_I(8'hFF), .MOTOR_SUPPLY_VOLTAGE_I(12'h800),
		.OUTPUT_VOLTAGE_I(12'h800), .RIPPLE_PULSE_OUTPUT_I(pulse_pin), .RIPPLE_PULSE_OUTPUT_O(pulse_o),
		.RIPPLE_PULSE_OUTPUT_OE_O(pulse_oe), .FAULT_OUTPUT_LOW_N_I(fault_pin),
		.FAULT_OUTPUT_LOW_N_O(fault_o), .FAULT_OUTPUT_LOW_N_OE_O(fault_oe));
	motor_partner i_motor (.clk_i(mclk), .rst_i(rst), .connected_i(connected), .pulse_oe_i(pulse_oe),
		.fault_oe_i(fault_oe), .sample_o(cur), .strobe_o(strobe), .pulse_pin_o(pulse_pin),
		.fault_pin_o(fault_pin));
	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask
	task automatic wait_count(input logic [15:0] target);
		for (int i = 0; i < 3000; i++) begin
			rd(`REG_COUNT, v);
			if (v >= target) break;
		end
	endtask
	task automatic setup(input logic [15:0] ctl, input logic conn);
		@(posedge mclk);
		rst <= 1'b1;
		connected <= conn;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		wr(`REG_MOTOR, 16'h00FF);
		wr(`REG_FILTER, 16'h4801);
		wr(`REG_THRESHOLD, 16'h0D01);
		wr(`REG_CONTROL, ctl);
	endtask
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd_chk(`REG_CONTROL, 16'h0000);
		rd_chk(`REG_MOTOR, 16'h0000);
		rd_chk(`REG_FILTER, 16'h4800);
		rd_chk(`REG_THRESHOLD, 16'h0C00);
		rd_chk(`REG_COUNT, 16'h0000);
		rd(`REG_STATUS, v);
		chk(v & 16'h0009, 16'h0008);
		rd_chk(8'h07, 16'h0000);
	endtask
	task automatic t_regs();
		logic [15:0] m;
		wr(`REG_CONTROL, 16'h007F);
		rd_chk(`REG_CONTROL, 16'h007D);
		wr(`REG_CONTROL, 16'h0000);
		for (int g = 0; g < 4; g++) begin
			m = {2'b00, g[1:0], g[1:0], g[1:0], 8'hFF};
			wr(`REG_MOTOR, m);
			rd_chk(`REG_MOTOR, m);
		end
		wr(`REG_THRESHOLD, 16'h3FFF);
		rd_chk(`REG_THRESHOLD, 16'h3FFF);
		wr(`REG_COUNT, 16'h1234);
		rd_chk(`REG_COUNT, 16'h0000);
		wr(8'h07, 16'hFFFF);
		rd_chk(8'h07, 16'h0000);
	endtask
	task automatic t_gates();
		setup(16'h0004, 1'b1);
		repeat (3000) @(posedge mclk);
		rd_chk(`REG_COUNT, 16'h0000);
		wr(`REG_CONTROL, 16'h000D);
		repeat (3000) @(posedge mclk);
		rd_chk(`REG_COUNT, 16'h0000);
	endtask
	task automatic t_count();
		setup(16'h0043, 1'b1);
		rd_chk(`REG_COUNT, 16'h0000);
		wait_count(16'h0008);
		chk(v, 16'h0008);
		rd(`REG_STATUS, v);
		chk(v & 16'h0009, 16'h0008);
		wait_count(16'h0009);
		rd(`REG_STATUS, v);
		chk(v & 16'h0009, 16'h0001);
		wr(`REG_CONTROL, 16'h0043);
		rd(`REG_STATUS, v);
		chk(v & 16'h0009, 16'h0008);
	endtask
	task automatic t_mute();
		setup(16'h0005, 1'b0);
		wait_count(16'h000D);
		chk({15'h0000, v > 16'h000C}, 16'h0001);
		setup(16'h0015, 1'b0);
		wait_count(16'h000C);
		repeat (3000) @(posedge mclk);
		rd_chk(`REG_COUNT, 16'h000C);
		rd(`REG_STATUS, v);
		chk(v & 16'h0006, 16'h0002);
	endtask
	// ------------------------------------------------------------
	// clock, sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 16'h0000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		connected = 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_gates();
		t_count();
		t_mute();
		conclude();
	end
	initial begin
		repeat (95000) @(posedge mclk);
		n_fail++;
		conclude();
	end
endmodule // motor_ripple_counter_tb_top
